// ---- rtl/cpm_top.sv ----
// capture block top: parameter access, settings and result registers
`timescale 1ns/1ps
module cpm_top
	import cpm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [CPM_PINS-1:0] trigPins,
	input wire logic [63:0] fb1Pos,
	input wire logic [63:0] fb2Pos,
	input wire logic [63:0] fb3Pos,
	input wire logic [63:0] loopPos,
	input wire logic [63:0] extEncPos,
	input wire logic [63:0] driveTime,
	input wire logic [63:0] dcTime,
	input wire logic dcSystem,
	input wire logic [7:0] paramAddr,
	input wire logic paramWr,
	input wire logic paramRd,
	input wire logic [63:0] paramWdata,
	output logic [63:0] paramRdata_reg,
	output logic paramAck_reg,
	output logic paramErr_reg
);
	import cpm_pkg::*;

	logic [CPM_PINS-1:0] pinsA_reg, pinsB_reg;
	logic [1:0] tickCnt_reg, tickCnt_next;
	logic tick_reg, tick_next;
	logic armReg [CPM_CHANNELS];
	logic armNext [CPM_CHANNELS];
	logic [1:0] evtReg [CPM_CHANNELS];
	logic [1:0] evtNext [CPM_CHANNELS];
	logic [7:0] smoothReg [CPM_CHANNELS];
	logic [7:0] smoothNext [CPM_CHANNELS];
	logic [7:0] kindReg [CPM_CHANNELS];
	logic [7:0] kindNext [CPM_CHANNELS];
	logic [CPM_CFG_W-1:0] cfgReg [CPM_CHANNELS];
	logic [CPM_CFG_W-1:0] cfgNext [CPM_CHANNELS];
	logic [63:0] posReg [CPM_CHANNELS];
	logic [63:0] posNext [CPM_CHANNELS];
	logic [63:0] timeReg [CPM_CHANNELS];
	logic [63:0] timeNext [CPM_CHANNELS];
	logic [63:0] dctReg [CPM_CHANNELS];
	logic [63:0] dctNext [CPM_CHANNELS];
	logic capPulse [CPM_CHANNELS];
	logic [63:0] capValue [CPM_CHANNELS];
	logic [63:0] paramRdata_next;
	logic paramAck_next, paramErr_next, hit;

	cpm_chan_if chIf [CPM_CHANNELS] ();

	// pins are asynchronous, two flops before use
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pinsA_reg <= '0;
			pinsB_reg <= '0;
		end else begin
			pinsA_reg <= trigPins;
			pinsB_reg <= pinsA_reg;
		end
	end

	// sampling tick divider, 40 ns rounds up to two cycles
	always_comb begin
		tickCnt_next = tickCnt_reg + 2'h1;
		tick_next = 1'b0;
		if (tickCnt_reg == 2'(CPM_TICK_CYCLES - 1)) begin // RULE16
			tickCnt_next = 2'h0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tickCnt_reg <= 2'h0;
			tick_reg <= 1'b0;
		end else begin
			tickCnt_reg <= tickCnt_next;
			tick_reg <= tick_next;
		end
	end

	// channels and their settings wiring
	for (genvar g = 0; g < CPM_CHANNELS; g++) begin : gChan
		assign chIf[g].trigSource = cfgReg[g][CPM_CFG_TRIG_LSB +: 5];
		assign chIf[g].trigEdge = cfgReg[g][CPM_CFG_EDGE_LSB +: 2];
		assign chIf[g].fbSource = cfgReg[g][CPM_CFG_FB_LSB +: 3];
		assign chIf[g].preSource = cfgReg[g][CPM_CFG_PRE_LSB +: 5];
		assign chIf[g].preEdge = cfgReg[g][CPM_CFG_PREEDGE_LSB +: 2];
		assign chIf[g].eventMode = evtReg[g];
		assign chIf[g].kind = kindReg[g];
		assign chIf[g].arm = armReg[g];
		assign capPulse[g] = chIf[g].capPulse;
		assign capValue[g] = chIf[g].capValue;

		cpm_channel uChan (
			.mclk(mclk),
			.rst_n(rst_n),
			.tick(tick_reg),
			.pinsSync(pinsB_reg),
			.fb1Pos(fb1Pos),
			.fb2Pos(fb2Pos),
			.fb3Pos(fb3Pos),
			.loopPos(loopPos),
			.extEncPos(extEncPos),
			.driveTime(driveTime),
			.dcTime(dcTime),
			.ch(chIf[g])
		);
	end

	// captures first, then parameter writes so a software set wins
	always_comb begin
		paramRdata_next = paramRdata_reg;
		paramAck_next = paramWr | paramRd;
		paramErr_next = 1'b0;
		hit = 1'b0;
		for (int c = 0; c < CPM_CHANNELS; c++) begin
			armNext[c] = armReg[c];
			evtNext[c] = evtReg[c];
			smoothNext[c] = smoothReg[c];
			kindNext[c] = kindReg[c];
			cfgNext[c] = cfgReg[c];
			posNext[c] = posReg[c];
			timeNext[c] = timeReg[c];
			dctNext[c] = dctReg[c];
			if (capPulse[c]) begin
				case (kindReg[c])
					CPM_KIND_TIME: timeNext[c] = capValue[c]; // RULE3
					CPM_KIND_DCT: dctNext[c] = capValue[c]; // RULE4
					default: posNext[c] = capValue[c]; // RULE2 RULE9
				endcase
				if (kindReg[c] != CPM_KIND_INDEX && kindReg[c] != CPM_KIND_AUTO) begin
					armNext[c] = 1'b0; // RULE13 RULE18
				end
			end
			if (paramWr) begin
				if (paramAddr == CPM_ADDR_ARM[c]) begin
					hit = 1'b1;
					armNext[c] = paramWdata[0];
					if (paramWdata[0]) begin
						posNext[c] = 64'h0; // arming clears the old position result
					end
				end else if (paramAddr == CPM_ADDR_EVENT[c]) begin
					hit = 1'b1;
					paramErr_next = paramWdata > CPM_EVENT_MAX;
					if (paramWdata <= CPM_EVENT_MAX) begin
						evtNext[c] = paramWdata[1:0];
					end
				end else if (paramAddr == CPM_ADDR_SMOOTH[c]) begin
					hit = 1'b1;
					paramErr_next = paramWdata > CPM_SMOOTH_MAX;
					if (paramWdata <= CPM_SMOOTH_MAX) begin
						smoothNext[c] = paramWdata[7:0]; // RULE12
					end
				end else if (paramAddr == CPM_ADDR_KIND[c]) begin
					hit = 1'b1;
					if (paramWdata > CPM_KIND_MAX) begin
						paramErr_next = 1'b1; // RULE17
					end else if (paramWdata[7:0] == CPM_KIND_DCT && !dcSystem) begin
						paramErr_next = 1'b1; // RULE5
					end else begin
						kindNext[c] = paramWdata[7:0]; // RULE1
						if (paramWdata[7:0] == CPM_KIND_INDEX) begin
							cfgNext[c][CPM_CFG_TRIG_LSB +: 5] = CPM_INDEX_TRIG; // RULE6
							cfgNext[c][CPM_CFG_EDGE_LSB +: 2] = CPM_EDGE_RISE; // RULE6
							evtNext[c] = CPM_EVENT_IGNORE; // RULE6
							armNext[c] = 1'b1; // RULE7
						end
					end
				end else if (paramAddr == CPM_ADDR_CFG[c]) begin
					hit = 1'b1;
					cfgNext[c] = paramWdata[CPM_CFG_W-1:0]; // RULE8
				end else if (paramAddr == CPM_ADDR_POS[c] || paramAddr == CPM_ADDR_TIME[c]) begin
					hit = 1'b1;
					paramErr_next = 1'b1; // RULE10
				end
			end
			if (paramRd) begin
				if (paramAddr == CPM_ADDR_ARM[c]) begin
					hit = 1'b1;
					paramRdata_next = {63'h0, armReg[c]};
				end else if (paramAddr == CPM_ADDR_EVENT[c]) begin
					hit = 1'b1;
					paramRdata_next = {62'h0, evtReg[c]};
				end else if (paramAddr == CPM_ADDR_SMOOTH[c]) begin
					hit = 1'b1;
					paramRdata_next = {56'h0, smoothReg[c]};
				end else if (paramAddr == CPM_ADDR_KIND[c]) begin
					hit = 1'b1;
					paramRdata_next = {56'h0, kindReg[c]};
				end else if (paramAddr == CPM_ADDR_CFG[c]) begin
					hit = 1'b1;
					paramRdata_next = {44'h0, cfgReg[c]};
				end else if (paramAddr == CPM_ADDR_POS[c]) begin
					hit = 1'b1;
					paramRdata_next = posReg[c]; // RULE10
				end else if (paramAddr == CPM_ADDR_TIME[c]) begin
					hit = 1'b1;
					paramRdata_next = timeReg[c];
				end
			end
		end
		if ((paramWr || paramRd) && !hit) begin
			paramErr_next = 1'b1; // unmapped address
		end
		if (paramRd && !hit) begin
			paramRdata_next = 64'h0;
		end
	end

	// settings, results and access answer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			paramRdata_reg <= 64'h0;
			paramAck_reg <= 1'b0;
			paramErr_reg <= 1'b0;
			for (int c = 0; c < CPM_CHANNELS; c++) begin
				armReg[c] <= 1'b0;
				evtReg[c] <= CPM_EVENT_IGNORE;
				smoothReg[c] <= 8'h00;
				kindReg[c] <= CPM_KIND_POS;
				cfgReg[c] <= CPM_CFG_RESET;
				posReg[c] <= 64'h0;
				timeReg[c] <= 64'h0;
				dctReg[c] <= 64'h0;
			end
		end else begin
			paramRdata_reg <= paramRdata_next;
			paramAck_reg <= paramAck_next;
			paramErr_reg <= paramErr_next;
			for (int c = 0; c < CPM_CHANNELS; c++) begin
				armReg[c] <= armNext[c];
				evtReg[c] <= evtNext[c];
				smoothReg[c] <= smoothNext[c];
				kindReg[c] <= kindNext[c];
				cfgReg[c] <= cfgNext[c];
				posReg[c] <= posNext[c];
				timeReg[c] <= timeNext[c];
				dctReg[c] <= dctNext[c];
			end
		end
	end

	// checks on channel 0, channel 1 shares the same logic
	property p_kind_reject;
		@(posedge mclk) disable iff (!rst_n)
		paramWr && paramAddr == CPM_ADDR_KIND[0] && paramWdata > CPM_KIND_MAX
		|=> paramErr_reg && paramAck_reg && $stable(kindReg[0]);
	endproperty
	a_kind_reject: assert property (p_kind_reject) else $error("bad kind accepted"); // RULE17
	property p_dct_reject;
		@(posedge mclk) disable iff (!rst_n)
		paramWr && paramAddr == CPM_ADDR_KIND[0] && paramWdata == 64'h2 && !dcSystem
		|=> paramErr_reg && $stable(kindReg[0]);
	endproperty
	a_dct_reject: assert property (p_dct_reject) else $error("clock kind accepted"); // RULE5
	property p_index_load;
		@(posedge mclk) disable iff (!rst_n)
		paramWr && paramAddr == CPM_ADDR_KIND[0] && paramWdata == 64'h3
		|=> chIf[0].trigSource == 5'h0A && chIf[0].trigEdge == 2'h1 && evtReg[0] == 2'h0;
	endproperty
	a_index_load: assert property (p_index_load) else $error("index settings not loaded"); // RULE6
	property p_index_arm;
		@(posedge mclk) disable iff (!rst_n)
		paramWr && paramAddr == CPM_ADDR_KIND[0] && paramWdata == 64'h3
		|=> armReg[0] ##1 (armReg[0] || $past(paramWr && paramAddr == CPM_ADDR_ARM[0]));
	endproperty
	a_index_arm: assert property (p_index_arm) else $error("index kind not armed"); // RULE7
	property p_arm_clear;
		@(posedge mclk) disable iff (!rst_n)
		capPulse[0] && kindReg[0] == 8'h00
		&& !(paramWr && (paramAddr == CPM_ADDR_ARM[0] || paramAddr == CPM_ADDR_KIND[0]))
		|=> !armReg[0];
	endproperty
	a_arm_clear: assert property (p_arm_clear) else $error("arm kept after capture"); // RULE13
	property p_rearm;
		@(posedge mclk) disable iff (!rst_n)
		capPulse[0] && kindReg[0] == 8'h04 && !paramWr |=> armReg[0];
	endproperty
	a_rearm: assert property (p_rearm) else $error("auto kind not re-armed"); // RULE9
	property p_pos_latch;
		@(posedge mclk) disable iff (!rst_n)
		capPulse[0] && kindReg[0] == 8'h00 && !paramWr |=> posReg[0] == $past(capValue[0]);
	endproperty
	a_pos_latch: assert property (p_pos_latch) else $error("position not latched"); // RULE2
	property p_time_latch;
		@(posedge mclk) disable iff (!rst_n)
		capPulse[0] && kindReg[0] == 8'h01 && !paramWr
		|=> timeReg[0] == $past(capValue[0]) && $stable(posReg[0]);
	endproperty
	a_time_latch: assert property (p_time_latch) else $error("time not latched"); // RULE3
	property p_smooth_range;
		@(posedge mclk) disable iff (!rst_n)
		paramWr && paramAddr == CPM_ADDR_SMOOTH[0] && paramWdata > 64'h2
		|=> paramErr_reg && $stable(smoothReg[0]);
	endproperty
	a_smooth_range: assert property (p_smooth_range) else $error("smoothing out of range"); // RULE12
endmodule

// ---- rtl/cpm_pkg.sv ----
// shared constants for the two-channel capture block
// Functional notes
// [RULE1] per channel 8-bit capture kind, 0..4, default 0
// [RULE2] kind 0 latches position from selected feedback
// [RULE3] kind 1 latches drive time, separate result
// [RULE4] kind 2 latches clock time, not readable
// [RULE5] kind 2 without clock-sync fieldbus is rejected
// [RULE6] kind 3 loads source 10, rising, ignore precondition
// [RULE7] kind 3 arms at once, re-triggers continuously
// [RULE8] loaded kind 3 settings stay writable by software
// [RULE9] kind 4 like kind 0 but re-arms itself
// [RULE10] position result read-only signed 64-bit, reset zero
// [RULE11] position scaled in selected source's own units
// [RULE12] smoothing select 0..2 stored, no effect
// [RULE13] arm clears after capture unless kind re-arms
// [RULE14] event modes: ignore, after edge, while high/low
// [RULE15] feedback source: three feedbacks, loop, external encoder
// [RULE16] 40 ns tick; same-tick edges are no trigger
// [RULE17] kind above 4 rejected, stored kind unchanged
// [RULE18] auto re-arm holds from cycle after store
package cpm_pkg;
	localparam int CPM_CHANNELS = 2;
	localparam int CPM_PINS = 32;
	// parameter access addresses, channel 0 then channel 1
	localparam logic [7:0] CPM_ADDR_ARM [CPM_CHANNELS] = '{8'h38, 8'h52};
	localparam logic [7:0] CPM_ADDR_EVENT [CPM_CHANNELS] = '{8'h3A, 8'h54};
	localparam logic [7:0] CPM_ADDR_SMOOTH [CPM_CHANNELS] = '{8'h3C, 8'h56};
	localparam logic [7:0] CPM_ADDR_KIND [CPM_CHANNELS] = '{8'h3E, 8'h58};
	localparam logic [7:0] CPM_ADDR_POS [CPM_CHANNELS] = '{8'h40, 8'h5A};
	localparam logic [7:0] CPM_ADDR_CFG [CPM_CHANNELS] = '{8'h70, 8'h71};
	localparam logic [7:0] CPM_ADDR_TIME [CPM_CHANNELS] = '{8'h72, 8'h73};
	// capture kinds
	localparam logic [7:0] CPM_KIND_POS = 8'h00;
	localparam logic [7:0] CPM_KIND_TIME = 8'h01;
	localparam logic [7:0] CPM_KIND_DCT = 8'h02;
	localparam logic [7:0] CPM_KIND_INDEX = 8'h03;
	localparam logic [7:0] CPM_KIND_AUTO = 8'h04;
	localparam logic [63:0] CPM_KIND_MAX = 64'h4;
	localparam logic [63:0] CPM_SMOOTH_MAX = 64'h2;
	localparam logic [63:0] CPM_EVENT_MAX = 64'h3;
	// configuration word fields
	localparam int CPM_CFG_W = 20;
	localparam int CPM_CFG_TRIG_LSB = 0;
	localparam int CPM_CFG_EDGE_LSB = 5;
	localparam int CPM_CFG_FB_LSB = 8;
	localparam int CPM_CFG_PRE_LSB = 12;
	localparam int CPM_CFG_PREEDGE_LSB = 18;
	localparam logic [CPM_CFG_W-1:0] CPM_CFG_RESET = 20'h40020;
	// automatic load for the index-homing kind
	localparam logic [4:0] CPM_INDEX_TRIG = 5'h0A;
	localparam logic [1:0] CPM_EDGE_RISE = 2'h1;
	localparam logic [1:0] CPM_EVENT_IGNORE = 2'h0;
	localparam logic [1:0] CPM_EVENT_AFTER = 2'h1;
	localparam logic [1:0] CPM_EVENT_HIGH = 2'h2;
	// feedback sources
	localparam logic [2:0] CPM_FB_ONE = 3'h0;
	localparam logic [2:0] CPM_FB_TWO = 3'h1;
	localparam logic [2:0] CPM_FB_THREE = 3'h2;
	localparam logic [2:0] CPM_FB_LOOP = 3'h3;
	localparam logic [2:0] CPM_FB_EXT = 3'h4;
	// trigger sampling tick, least time rounded up
	localparam int CPM_CLK_PERIOD_PS = 25000;
	localparam int CPM_TICK_NS = 40;
	localparam int CPM_TICK_CYCLES = (CPM_TICK_NS * 1000 + CPM_CLK_PERIOD_PS - 1) / CPM_CLK_PERIOD_PS;
endpackage

// ---- rtl/cpm_chan_if.sv ----
// settings and capture result passed between top and one channel
`timescale 1ns/1ps
interface cpm_chan_if;
	logic [4:0] trigSource;
	logic [1:0] trigEdge;
	logic [1:0] eventMode;
	logic [2:0] fbSource;
	logic [4:0] preSource;
	logic [1:0] preEdge;
	logic [7:0] kind;
	logic arm;
	logic capPulse;
	logic [63:0] capValue;
	modport top (output trigSource, trigEdge, eventMode, fbSource, preSource, preEdge, kind, arm,
		input capPulse, capValue);
	modport chan (input trigSource, trigEdge, eventMode, fbSource, preSource, preEdge, kind, arm,
		output capPulse, capValue);
endinterface

// ---- rtl/cpm_channel.sv ----
// one capture channel: edge and precondition logic plus value select
`timescale 1ns/1ps
module cpm_channel
	import cpm_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic [CPM_PINS-1:0] pinsSync,
	input wire logic [63:0] fb1Pos,
	input wire logic [63:0] fb2Pos,
	input wire logic [63:0] fb3Pos,
	input wire logic [63:0] loopPos,
	input wire logic [63:0] extEncPos,
	input wire logic [63:0] driveTime,
	input wire logic [63:0] dcTime,
	cpm_chan_if.chan ch
);
	import cpm_pkg::*;

	logic trigPrev_reg, trigPrev_next;
	logic prePrev_reg, prePrev_next;
	logic preSeen_reg, preSeen_next;
	logic cap_reg, cap_next;
	logic [63:0] value_reg, value_next;
	logic trigNow, preNow, trigHit, preHit, fire;
	logic [63:0] srcValue;

	// quantity picked by kind, position units follow the source
	always_comb begin
		case (ch.fbSource) // RULE15 RULE11
			CPM_FB_ONE: srcValue = fb1Pos;
			CPM_FB_TWO: srcValue = fb2Pos;
			CPM_FB_THREE: srcValue = fb3Pos;
			CPM_FB_LOOP: srcValue = loopPos;
			CPM_FB_EXT: srcValue = extEncPos;
			default: srcValue = 64'h0;
		endcase
		if (ch.kind == CPM_KIND_TIME) begin
			srcValue = driveTime; // RULE3
		end else if (ch.kind == CPM_KIND_DCT) begin
			srcValue = dcTime; // RULE4
		end
	end

	// trigger evaluation only on the sampling tick
	always_comb begin
		trigNow = pinsSync[ch.trigSource];
		preNow = pinsSync[ch.preSource];
		trigHit = (ch.trigEdge[0] & trigNow & ~trigPrev_reg) | (ch.trigEdge[1] & ~trigNow & trigPrev_reg);
		preHit = (ch.preEdge[0] & preNow & ~prePrev_reg) | (ch.preEdge[1] & ~preNow & prePrev_reg);
		case (ch.eventMode) // RULE14
			CPM_EVENT_IGNORE: fire = trigHit;
			CPM_EVENT_AFTER: fire = trigHit & preSeen_reg & ~preHit; // RULE16
			CPM_EVENT_HIGH: fire = trigHit & preNow;
			default: fire = trigHit & ~preNow;
		endcase
		fire = fire & tick & ch.arm;
		trigPrev_next = tick ? trigNow : trigPrev_reg;
		prePrev_next = tick ? preNow : prePrev_reg;
		preSeen_next = preSeen_reg;
		if (!ch.arm || fire) begin
			preSeen_next = 1'b0; // a fresh precondition edge is needed per capture
		end else if (tick && preHit) begin
			preSeen_next = 1'b1;
		end
		cap_next = fire;
		value_next = fire ? srcValue : value_reg;
	end

	// channel state registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			trigPrev_reg <= 1'b0;
			prePrev_reg <= 1'b0;
			preSeen_reg <= 1'b0;
			cap_reg <= 1'b0;
			value_reg <= 64'h0;
		end else begin
			trigPrev_reg <= trigPrev_next;
			prePrev_reg <= prePrev_next;
			preSeen_reg <= preSeen_next;
			cap_reg <= cap_next;
			value_reg <= value_next;
		end
	end

	assign ch.capPulse = cap_reg;
	assign ch.capValue = value_reg;

	property p_same_tick;
		@(posedge mclk) disable iff (!rst_n)
		tick && ch.eventMode == CPM_EVENT_AFTER && preHit |=> !cap_reg;
	endproperty
	a_same_tick: assert property (p_same_tick) else $error("same-tick precondition fired"); // RULE16
endmodule

// ---- verification/cpm_feedback_model.sv ----
// trigger pin and position feedback model facing the capture block
`timescale 1ns/1ps
module cpm_feedback_model
	import cpm_pkg::*;
#(
	parameter int PULSE_CYCLES = 6
)(
	input wire logic mclk,
	input wire logic pulseReq,
	input wire logic [4:0] pulsePin,
	input wire logic [63:0] basePos,
	output logic [CPM_PINS-1:0] trigPins = '0,
	output logic [63:0] fb1Pos,
	output logic [63:0] fb2Pos,
	output logic [63:0] fb3Pos,
	output logic [63:0] loopPos,
	output logic [63:0] extEncPos,
	output logic [63:0] driveTime,
	output logic [63:0] dcTime
);
	int holdCnt = 0;
	// pin held over several ticks so the two-flop sync and the 40 ns sampler both see it
	always @(posedge mclk) begin
		if (pulseReq) begin
			trigPins <= CPM_PINS'(1) << pulsePin;
			holdCnt <= PULSE_CYCLES;
		end else if (holdCnt > 1) begin
			holdCnt <= holdCnt - 1;
		end else begin
			trigPins <= '0;
			holdCnt <= 0;
		end
	end
	// sources distinct from each other so a wrong selection shows
	assign fb1Pos = basePos;
	assign fb2Pos = basePos + 64'h1;
	assign fb3Pos = basePos + 64'h2;
	assign loopPos = basePos + 64'h3;
	assign extEncPos = basePos + 64'h4;
	assign driveTime = ~basePos;
	assign dcTime = basePos ^ 64'h5A5A_5A5A_5A5A_5A5A;
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench for the two-channel capture block
`timescale 1ns/1ps
module tb_top;
	import cpm_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic dcSystem = 1'b0;
	logic [7:0] paramAddr = 8'h00;
	logic paramWr = 1'b0;
	logic paramRd = 1'b0;
	logic [63:0] paramWdata = 64'h0;
	logic pulseReq = 1'b0;
	logic [4:0] pulsePin = 5'h00;
	// negative start value exercises the signed range
	logic [63:0] basePos = 64'hFFFF_FFFF_FFFF_FF00;
	logic [CPM_PINS-1:0] trigPins;
	logic [63:0] fb1Pos, fb2Pos, fb3Pos, loopPos, extEncPos, driveTime, dcTime;
	logic [63:0] paramRdata_reg;
	logic paramAck_reg;
	logic paramErr_reg;
	logic [63:0] prev;
	int fails = 0;
	int compares = 0;

	cpm_feedback_model u_feedback (.mclk, .pulseReq, .pulsePin, .basePos, .trigPins, .fb1Pos,
		.fb2Pos, .fb3Pos, .loopPos, .extEncPos, .driveTime, .dcTime);
	cpm_top u_dut (.mclk, .rst_n, .trigPins, .fb1Pos, .fb2Pos, .fb3Pos, .loopPos, .extEncPos,
		.driveTime, .dcTime, .dcSystem, .paramAddr, .paramWr, .paramRd, .paramWdata,
		.paramRdata_reg, .paramAck_reg, .paramErr_reg);

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	task automatic report_and_stop();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check64(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic checkBit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one strobe cycle, then a bounded wait for the registered answer
	task automatic access(input logic wr, input logic [7:0] a, input logic [63:0] d,
		output logic [63:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge mclk);
		paramAddr <= a;
		paramWdata <= d;
		paramWr <= wr;
		paramRd <= ~wr;
		@(posedge mclk);
		paramWr <= 1'b0;
		paramRd <= 1'b0;
		#1;
		while (paramAck_reg !== 1'b1 && n < 3) begin
			@(posedge mclk);
			#1;
			n++;
		end
		checkBit(paramAck_reg, 1'b1);
		rd = paramRdata_reg;
		er = paramErr_reg;
	endtask

	task automatic wrReg(input logic [7:0] a, input logic [63:0] d, input logic expErr);
		logic [63:0] rd;
		logic er;
		access(1'b1, a, d, rd, er);
		checkBit(er, expErr);
	endtask

	task automatic rdReg(input logic [7:0] a, input logic [63:0] exp);
		logic [63:0] rd;
		logic er;
		access(1'b0, a, 64'h0, rd, er);
		checkBit(er, 1'b0);
		check64(rd, exp);
	endtask

	// long enough for sync, tick, latch and store before the next access
	task automatic pulse(input logic [4:0] pin);
		@(posedge mclk);
		pulsePin <= pin;
		pulseReq <= 1'b1;
		@(posedge mclk);
		pulseReq <= 1'b0;
		repeat (12) @(posedge mclk);
	endtask

	task automatic moveBase();
		@(posedge mclk);
		basePos <= basePos - 64'h100;
		@(posedge mclk);
	endtask

	function automatic logic [63:0] cfgWord(input logic [4:0] trig, input logic [2:0] fb);
		return (64'(CPM_EDGE_RISE) << CPM_CFG_PREEDGE_LSB) | (64'(fb) << CPM_CFG_FB_LSB)
			| (64'(CPM_EDGE_RISE) << CPM_CFG_EDGE_LSB) | 64'(trig);
	endfunction

	function automatic logic [63:0] fbExp(input int src);
		return basePos + 64'(src);
	endfunction

	// hang guard, far above the roughly 400 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		// reset values, refused writes leave the stores alone
		for (int c = 0; c < CPM_CHANNELS; c++) begin
			rdReg(CPM_ADDR_KIND[c], 64'h0);
			rdReg(CPM_ADDR_SMOOTH[c], 64'h0);
			rdReg(CPM_ADDR_POS[c], 64'h0);
			rdReg(CPM_ADDR_ARM[c], 64'h0);
			rdReg(CPM_ADDR_EVENT[c], 64'h0);
			wrReg(CPM_ADDR_EVENT[c], 64'h4, 1'b1);
			rdReg(CPM_ADDR_EVENT[c], 64'h0);
			wrReg(CPM_ADDR_KIND[c], 64'h5, 1'b1);
			wrReg(CPM_ADDR_SMOOTH[c], 64'h3, 1'b1);
			wrReg(CPM_ADDR_SMOOTH[c], 64'h2, 1'b0);
			wrReg(CPM_ADDR_POS[c], 64'h1, 1'b1);
			wrReg(CPM_ADDR_KIND[c], 64'h2, 1'b1);
			rdReg(CPM_ADDR_KIND[c], 64'h0);
			rdReg(CPM_ADDR_SMOOTH[c], 64'h2);
		end
		wrReg(8'h00, 64'h0, 1'b1);
		// clock-time kind once the sync fieldbus is present; nothing reaches the position
		@(posedge mclk);
		dcSystem <= 1'b1;
		wrReg(CPM_ADDR_KIND[0], 64'h2, 1'b0);
		rdReg(CPM_ADDR_KIND[0], 64'h2);
		wrReg(CPM_ADDR_ARM[0], 64'h1, 1'b0);
		pulse(5'h00);
		rdReg(CPM_ADDR_POS[0], 64'h0);
		rdReg(CPM_ADDR_ARM[0], 64'h0);
		// plain position through every source, smoothing left at 2
		wrReg(CPM_ADDR_KIND[0], 64'h0, 1'b0);
		for (int s = 0; s < 5; s++) begin
			wrReg(CPM_ADDR_CFG[0], cfgWord(5'h03, 3'(s)), 1'b0);
			wrReg(CPM_ADDR_ARM[0], 64'h1, 1'b0);
			pulse(5'h03);
			rdReg(CPM_ADDR_POS[0], fbExp(s));
			rdReg(CPM_ADDR_ARM[0], 64'h0);
		end
		// a later edge without a new arm must not overwrite
		prev = fbExp(4);
		moveBase();
		pulse(5'h03);
		rdReg(CPM_ADDR_POS[0], prev);
		wrReg(CPM_ADDR_ARM[0], 64'h1, 1'b0);
		rdReg(CPM_ADDR_POS[0], 64'h0);
		// drive time kind, position result left alone
		wrReg(CPM_ADDR_KIND[0], 64'h1, 1'b0);
		pulse(5'h03);
		rdReg(CPM_ADDR_TIME[0], ~basePos);
		rdReg(CPM_ADDR_POS[0], 64'h0);
		// auto re-arm kind on channel 1: one arm, two captures
		wrReg(CPM_ADDR_CFG[1], cfgWord(5'h04, 3'h3), 1'b0);
		wrReg(CPM_ADDR_KIND[1], 64'h4, 1'b0);
		wrReg(CPM_ADDR_ARM[1], 64'h1, 1'b0);
		pulse(5'h04);
		rdReg(CPM_ADDR_POS[1], fbExp(3));
		moveBase();
		pulse(5'h04);
		rdReg(CPM_ADDR_POS[1], fbExp(3));
		rdReg(CPM_ADDR_ARM[1], 64'h1);
		// precondition pin 0 stays low: while-high blocks, while-low passes
		wrReg(CPM_ADDR_EVENT[1], 64'h2, 1'b0);
		wrReg(CPM_ADDR_ARM[1], 64'h1, 1'b0);
		pulse(5'h04);
		rdReg(CPM_ADDR_POS[1], 64'h0);
		wrReg(CPM_ADDR_EVENT[1], 64'h3, 1'b0);
		pulse(5'h04);
		rdReg(CPM_ADDR_POS[1], fbExp(3));
		// precondition on the trigger pin: both edges in one tick, never a trigger
		wrReg(CPM_ADDR_CFG[1], cfgWord(5'h04, 3'h3) | (64'h4 << CPM_CFG_PRE_LSB), 1'b0);
		wrReg(CPM_ADDR_EVENT[1], 64'h1, 1'b0);
		wrReg(CPM_ADDR_ARM[1], 64'h1, 1'b0);
		pulse(5'h04);
		rdReg(CPM_ADDR_POS[1], 64'h0);
		// index homing kind overrides trigger, edge and event, keeps the source
		wrReg(CPM_ADDR_EVENT[0], 64'h2, 1'b0);
		// falling edge beforehand so the loaded rising edge shows
		wrReg(CPM_ADDR_CFG[0], cfgWord(5'h03, 3'h1) ^ (64'h3 << CPM_CFG_EDGE_LSB), 1'b0);
		wrReg(CPM_ADDR_KIND[0], 64'h3, 1'b0);
		rdReg(CPM_ADDR_CFG[0], cfgWord(5'h0A, 3'h1));
		rdReg(CPM_ADDR_EVENT[0], 64'h0);
		rdReg(CPM_ADDR_ARM[0], 64'h1);
		pulse(5'h0A);
		rdReg(CPM_ADDR_POS[0], fbExp(1));
		moveBase();
		pulse(5'h0A);
		rdReg(CPM_ADDR_POS[0], fbExp(1));
		// loaded settings stay writable, index moved to another pin
		wrReg(CPM_ADDR_CFG[0], cfgWord(5'h05, 3'h1), 1'b0);
		rdReg(CPM_ADDR_CFG[0], cfgWord(5'h05, 3'h1));
		report_and_stop();
	end
endmodule
